// ---- tbfc_cfg.svh ----
`ifndef TBFC_CFG_SVH
`define TBFC_CFG_SVH

`define TBFC_PRE1          8'h55
`define TBFC_PRE2          8'hFF
`define TBFC_PAD           8'hFF
`define TBFC_BCAST         8'hFF
`define TBFC_FT_TOKEN      8'h00
`define TBFC_FT_PFM        8'h01
`define TBFC_FT_RPFM       8'h02
`define TBFC_FT_IPV6       8'h0A
`define TBFC_DATA_MAX      1501
`define TBFC_DCRC_BYTES    4
`define TBFC_COBS_BLOCK    254
`define TBFC_LEN_BIAS      16'h0002
`define TBFC_CLK_HZ        50000000
`define TBFC_TICK_MS       5
`define TBFC_TICK_CYC      ((`TBFC_CLK_HZ / 1000) * `TBFC_TICK_MS)
`define TBFC_FIFO_DEPTH    16

`endif

// ---- tbfc_pkg.sv ----
package tbfc_pkg;

  typedef enum logic [3:0] {
    TX_IDLE = 4'b0000,
    TX_PRE1 = 4'b0001,
    TX_PRE2 = 4'b0010,
    TX_TYPE = 4'b0011,
    TX_DEST = 4'b0100,
    TX_SRC  = 4'b0101,
    TX_LENH = 4'b0110,
    TX_LENL = 4'b0111,
    TX_HCHK = 4'b1000,
    TX_DATA = 4'b1001,
    TX_PAD  = 4'b1010
  } tbfc_tx_e;

  typedef enum logic [3:0] {
    RX_HUNT = 4'b0000,
    RX_PRE2 = 4'b0001,
    RX_TYPE = 4'b0010,
    RX_DEST = 4'b0011,
    RX_SRC  = 4'b0100,
    RX_LENH = 4'b0101,
    RX_LENL = 4'b0110,
    RX_HCHK = 4'b0111,
    RX_HVER = 4'b1000,
    RX_DATA = 4'b1001,
    RX_DVER = 4'b1010
  } tbfc_rx_e;

  typedef enum logic [2:0] {
    KIND_TOKEN = 3'b000,
    KIND_PFM   = 3'b001,
    KIND_RPFM  = 3'b010,
    KIND_IPV6  = 3'b011,
    KIND_OTHER = 3'b100
  } tbfc_kind_e;

endpackage

// ---- tbfc_stream_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface tbfc_stream_if #(
  parameter int WIDTH = 8
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// ---- tbfc_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none

module tbfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             wr_valid_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output var  logic             wr_ready_out,
  tbfc_stream_if.src            rd
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign wr_ready_out = (count_r != (AW+1)'(DEPTH));
  assign rd.valid     = (count_r != '0);
  assign rd.data      = mem[rd_ptr_r];
  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = rd.valid && rd.ready;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr_r] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

// ---- tbfc_frame_codec.sv ----
// What this block does
// - every sent frame opens with octets 0x55 then 0xFF
// - frame type octet follows preamble; receiver classifies frames by it
// - destination address octet, then source address octet
// - two-octet length, most significant octet first, both directions
// - one header check octet closes the header before data
// - payloads from zero to 1501 octets are accepted and generated
// - data followed by 32-bit check value, low octet first
// - encoded data and check sent together, omitted when length is zero
// - optional single 0xFF pad after frame; receiver tolerates either
// - type 0 token, 1 poll-for-master, 2 reply to poll
// - data frames start only while the token is held
// - after the configured frame count the token must be passed on
// - a 5 ms timer tick is provided for link timing
// - type 10 marks encapsulated IPv6 frames
// - non-zero length equals encoded octet count minus two
// - header check covers type, addresses and length
// - destination 255 is broadcast; source 255 never used
`timescale 1ns/1ps
`default_nettype none
`include "tbfc_cfg.svh"

module tbfc_frame_codec import tbfc_pkg::*; #(
  parameter int unsigned TICK_CYC   = `TBFC_TICK_CYC,
  parameter int          FIFO_DEPTH = `TBFC_FIFO_DEPTH
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  my_addr_in,
  input  wire logic        token_held_in,
  input  wire logic [7:0]  max_frames_in,
  output var  logic        pass_due_out,
  output var  logic        tick_5ms_out,
  input  wire logic        tx_req_in,
  input  wire logic [7:0]  tx_type_in,
  input  wire logic [7:0]  tx_dest_in,
  input  wire logic [15:0] tx_len_in,
  input  wire logic [7:0]  tx_hchk_in,
  input  wire logic        tx_pad_in,
  output var  logic        tx_busy_out,
  output var  logic        tx_refused_out,
  output var  logic        tx_done_out,
  input  wire logic        pay_valid_in,
  input  wire logic [7:0]  pay_data_in,
  output var  logic        pay_ready_out,
  output var  logic        tx_valid_out,
  output var  logic [7:0]  tx_byte_out,
  input  wire logic        tx_ready_in,
  output var  logic        drv_oe_n_out,
  input  wire logic        rx_valid_in,
  input  wire logic [7:0]  rx_byte_in,
  input  wire logic        rx_hchk_ok_in,
  input  wire logic        rx_dchk_ok_in,
  output var  logic        rx_hdr_valid_out,
  output var  logic [7:0]  rx_type_out,
  output var  logic [2:0]  rx_kind_out,
  output var  logic [7:0]  rx_dest_out,
  output var  logic [7:0]  rx_src_out,
  output var  logic [15:0] rx_len_out,
  output var  logic        rx_data_valid_out,
  output var  logic [7:0]  rx_data_out,
  output var  logic        rx_frame_ok_out,
  output var  logic        rx_hdr_err_out,
  output var  logic        rx_data_err_out
);
  // longest length field: data plus check, plus stuffing overhead, less bias
  localparam int LEN_MAX = `TBFC_DATA_MAX + `TBFC_DCRC_BYTES
    + (`TBFC_DATA_MAX + `TBFC_DCRC_BYTES + `TBFC_COBS_BLOCK - 1) / `TBFC_COBS_BLOCK
    - 2;

  function automatic logic is_ctrl(input logic [7:0] ft);
    is_ctrl = (ft == `TBFC_FT_TOKEN) || (ft == `TBFC_FT_PFM) || (ft == `TBFC_FT_RPFM);
  endfunction

  // encoded octets on the wire for a given length field
  function automatic logic [15:0] wire_count(input logic [15:0] len);
    wire_count = len + `TBFC_LEN_BIAS;
  endfunction

  tbfc_stream_if #(.WIDTH(8)) pay_q ();

  tbfc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .wr_valid_in  (pay_valid_in),
    .wr_data_in   (pay_data_in),
    .wr_ready_out (pay_ready_out),
    .rd           (pay_q)
  );

  logic [31:0] tick_cnt_r;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tick_cnt_r   <= '0;
      tick_5ms_out <= 1'b0;
    end else if (tick_cnt_r == TICK_CYC - 1) begin
      tick_cnt_r   <= '0;
      tick_5ms_out <= 1'b1;
    end else begin
      tick_cnt_r   <= tick_cnt_r + 32'h0000_0001;
      tick_5ms_out <= 1'b0;
    end
  end

  tbfc_tx_e    tx_st_r;
  logic [7:0]  t_type_r;
  logic [7:0]  t_dest_r;
  logic [15:0] t_len_r;
  logic [7:0]  t_hchk_r;
  logic        t_pad_r;
  logic [15:0] t_cnt_r;
  logic [7:0]  frames_r;
  logic        can_load;
  logic        accept;
  logic        refuse;

  assign pass_due_out = token_held_in && (frames_r >= max_frames_in);
  assign can_load     = !tx_valid_out || tx_ready_in;
  assign tx_busy_out  = (tx_st_r != TX_IDLE);
  assign drv_oe_n_out = (tx_st_r == TX_IDLE) && !tx_valid_out;
  assign pay_q.ready  = (tx_st_r == TX_DATA) && can_load;

  always_comb begin
    refuse = 1'b0;
    // own address must not be broadcast
    if (my_addr_in == `TBFC_BCAST) begin
      refuse = 1'b1;
    end
    if (tx_len_in > 16'(LEN_MAX)) begin
      refuse = 1'b1;
    end
    if (!is_ctrl(tx_type_in) && (!token_held_in || pass_due_out)) begin
      refuse = 1'b1;
    end
  end
  assign accept = tx_req_in && (tx_st_r == TX_IDLE) && !refuse;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_refused_out <= 1'b0;
    end else begin
      tx_refused_out <= tx_req_in && (tx_st_r == TX_IDLE) && refuse;
    end
  end

  // count data frames while token held
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      frames_r <= '0;
    end else if (!token_held_in) begin
      frames_r <= '0;
    end else if (accept && !is_ctrl(tx_type_in)) begin
      frames_r <= frames_r + 8'h01;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      t_type_r <= '0;
      t_dest_r <= '0;
      t_len_r  <= '0;
      t_hchk_r <= '0;
      t_pad_r  <= 1'b0;
    end else if (accept) begin
      t_type_r <= tx_type_in;
      t_dest_r <= tx_dest_in;
      t_len_r  <= tx_len_in;
      t_hchk_r <= tx_hchk_in;
      t_pad_r  <= tx_pad_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_st_r      <= TX_IDLE;
      tx_valid_out <= 1'b0;
      tx_byte_out  <= '0;
      t_cnt_r      <= '0;
      tx_done_out  <= 1'b0;
    end else begin
      tx_done_out <= 1'b0;
      if (tx_valid_out && tx_ready_in) begin
        tx_valid_out <= 1'b0;
      end
      if (can_load) begin
        case (tx_st_r)
          TX_IDLE: begin
            if (accept) begin
              tx_st_r <= TX_PRE1;
            end
          end
          TX_PRE1: begin
            tx_byte_out  <= `TBFC_PRE1;
            tx_valid_out <= 1'b1;
            tx_st_r      <= TX_PRE2;
          end
          TX_PRE2: begin
            tx_byte_out  <= `TBFC_PRE2;
            tx_valid_out <= 1'b1;
            tx_st_r      <= TX_TYPE;
          end
          TX_TYPE: begin
            tx_byte_out  <= t_type_r;
            tx_valid_out <= 1'b1;
            tx_st_r      <= TX_DEST;
          end
          TX_DEST: begin
            tx_byte_out  <= t_dest_r;
            tx_valid_out <= 1'b1;
            tx_st_r      <= TX_SRC;
          end
          TX_SRC: begin
            tx_byte_out  <= my_addr_in;
            tx_valid_out <= 1'b1;
            tx_st_r      <= TX_LENH;
          end
          TX_LENH: begin
            tx_byte_out  <= t_len_r[15:8];
            tx_valid_out <= 1'b1;
            tx_st_r      <= TX_LENL;
          end
          TX_LENL: begin
            tx_byte_out  <= t_len_r[7:0];
            tx_valid_out <= 1'b1;
            tx_st_r      <= TX_HCHK;
          end
          TX_HCHK: begin
            tx_byte_out  <= t_hchk_r;
            tx_valid_out <= 1'b1;
            t_cnt_r      <= wire_count(t_len_r);
            // no data field for zero length
            if (t_len_r == 16'h0000) begin
              tx_st_r <= t_pad_r ? TX_PAD : TX_IDLE;
              tx_done_out <= !t_pad_r;
            end else begin
              tx_st_r <= TX_DATA;
            end
          end
          TX_DATA: begin
            if (pay_q.valid) begin
              tx_byte_out  <= pay_q.data;
              tx_valid_out <= 1'b1;
              t_cnt_r      <= t_cnt_r - 16'h0001;
              if (t_cnt_r == 16'h0001) begin
                tx_st_r     <= t_pad_r ? TX_PAD : TX_IDLE;
                tx_done_out <= !t_pad_r;
              end
            end
          end
          TX_PAD: begin
            tx_byte_out  <= `TBFC_PAD;
            tx_valid_out <= 1'b1;
            tx_st_r      <= TX_IDLE;
            tx_done_out  <= 1'b1;
          end
          default: begin
            tx_st_r <= TX_IDLE;
          end
        endcase
      end
    end
  end

  tbfc_rx_e    rx_st_r;
  logic [15:0] r_cnt_r;
  logic        for_me;

  // accept own address or broadcast; reject source 255
  assign for_me = ((rx_dest_out == my_addr_in) || (rx_dest_out == `TBFC_BCAST))
    && (rx_src_out != `TBFC_BCAST);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_st_r           <= RX_HUNT;
      r_cnt_r           <= '0;
      rx_type_out       <= '0;
      rx_kind_out       <= KIND_TOKEN;
      rx_dest_out       <= '0;
      rx_src_out        <= '0;
      rx_len_out        <= '0;
      rx_hdr_valid_out  <= 1'b0;
      rx_data_valid_out <= 1'b0;
      rx_data_out       <= '0;
      rx_frame_ok_out   <= 1'b0;
      rx_hdr_err_out    <= 1'b0;
      rx_data_err_out   <= 1'b0;
    end else begin
      rx_hdr_valid_out  <= 1'b0;
      rx_data_valid_out <= 1'b0;
      rx_frame_ok_out   <= 1'b0;
      rx_hdr_err_out    <= 1'b0;
      rx_data_err_out   <= 1'b0;
      case (rx_st_r)
        // hunt for preamble; pad octets fall away here
        RX_HUNT: begin
          if (rx_valid_in && rx_byte_in == `TBFC_PRE1) begin
            rx_st_r <= RX_PRE2;
          end
        end
        RX_PRE2: begin
          if (rx_valid_in) begin
            if (rx_byte_in == `TBFC_PRE2) begin
              rx_st_r <= RX_TYPE;
            end else if (rx_byte_in != `TBFC_PRE1) begin
              rx_st_r <= RX_HUNT;
            end
          end
        end
        RX_TYPE: begin
          if (rx_valid_in) begin
            rx_type_out <= rx_byte_in;
            case (rx_byte_in)
              `TBFC_FT_TOKEN: rx_kind_out <= KIND_TOKEN;
              `TBFC_FT_PFM:   rx_kind_out <= KIND_PFM;
              `TBFC_FT_RPFM:  rx_kind_out <= KIND_RPFM;
              `TBFC_FT_IPV6:  rx_kind_out <= KIND_IPV6;
              default:        rx_kind_out <= KIND_OTHER;
            endcase
            rx_st_r <= RX_DEST;
          end
        end
        RX_DEST: begin
          if (rx_valid_in) begin
            rx_dest_out <= rx_byte_in;
            rx_st_r     <= RX_SRC;
          end
        end
        RX_SRC: begin
          if (rx_valid_in) begin
            rx_src_out <= rx_byte_in;
            rx_st_r    <= RX_LENH;
          end
        end
        RX_LENH: begin
          if (rx_valid_in) begin
            rx_len_out[15:8] <= rx_byte_in;
            rx_st_r          <= RX_LENL;
          end
        end
        RX_LENL: begin
          if (rx_valid_in) begin
            rx_len_out[7:0] <= rx_byte_in;
            rx_st_r         <= RX_HCHK;
          end
        end
        RX_HCHK: begin
          if (rx_valid_in) begin
            r_cnt_r <= wire_count(rx_len_out);
            rx_st_r <= RX_HVER;
          end
        end
        // external engine judges header, one cycle after check octet
        RX_HVER: begin
          if (!rx_hchk_ok_in || rx_len_out > 16'(LEN_MAX)) begin
            rx_hdr_err_out <= 1'b1;
            rx_st_r        <= RX_HUNT;
          end else if (!for_me) begin
            rx_st_r <= RX_HUNT;
          end else begin
            rx_hdr_valid_out <= 1'b1;
            if (rx_len_out == 16'h0000) begin
              rx_frame_ok_out <= 1'b1;
              rx_st_r         <= RX_HUNT;
            end else begin
              rx_st_r <= RX_DATA;
            end
          end
        end
        // count len plus two encoded octets
        RX_DATA: begin
          if (rx_valid_in) begin
            rx_data_out       <= rx_byte_in;
            rx_data_valid_out <= 1'b1;
            r_cnt_r           <= r_cnt_r - 16'h0001;
            if (r_cnt_r == 16'h0001) begin
              rx_st_r <= RX_DVER;
            end
          end
        end
        // data check result one cycle after last octet
        RX_DVER: begin
          rx_st_r <= RX_HUNT;
          if (rx_dchk_ok_in) begin
            rx_frame_ok_out <= 1'b1;
          end else begin
            rx_data_err_out <= 1'b1;
          end
        end
        default: begin
          rx_st_r <= RX_HUNT;
        end
      endcase
    end
  end
endmodule

`default_nettype wire

// ---- tbfc_frame_codec_sva.sv ----
`timescale 1ns/1ps
`default_nettype none

module tbfc_frame_codec_sva #(
  parameter int unsigned TICK_CYC = 10
) (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic [7:0]  my_addr_in,
  input wire logic        token_held_in,
  input wire logic        pass_due_out,
  input wire logic        tick_5ms_out,
  input wire logic        tx_req_in,
  input wire logic [7:0]  tx_type_in,
  input wire logic [15:0] tx_len_in,
  input wire logic        tx_busy_out,
  input wire logic        tx_refused_out,
  input wire logic        tx_done_out,
  input wire logic        tx_valid_out,
  input wire logic [7:0]  tx_byte_out,
  input wire logic        tx_ready_in,
  input wire logic        drv_oe_n_out,
  input wire logic        rx_hchk_ok_in,
  input wire logic        rx_dchk_ok_in,
  input wire logic        rx_hdr_valid_out,
  input wire logic [7:0]  rx_type_out,
  input wire logic [2:0]  rx_kind_out,
  input wire logic [7:0]  rx_dest_out,
  input wire logic [7:0]  rx_src_out,
  input wire logic        rx_data_err_out
);
  logic [31:0] cnt_r;
  logic        seen_r;

  default clocking cb_main @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // counter instead of a long repetition, which the tools would unroll
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r  <= 32'h0;
      seen_r <= 1'b0;
    end else if (tick_5ms_out) begin
      cnt_r  <= 32'h0;
      seen_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h1;
    end
  end

  sequence s_tx_start;
    $rose(tx_busy_out) ##1 (tx_valid_out && tx_byte_out == 8'h55);
  endsequence
  sequence s_pre_take;
    tx_valid_out && tx_ready_in && tx_byte_out == 8'h55 && !$past(tx_valid_out);
  endsequence

  property p_pre_first;
    $rose(tx_busy_out) |-> s_tx_start;
  endproperty
  a_pre_first: assert property (p_pre_first)
    else $error("frame did not open with 55");
  property p_pre_second;
    s_pre_take |=> tx_valid_out && tx_byte_out == 8'hFF;
  endproperty
  a_pre_second: assert property (p_pre_second)
    else $error("second opening octet not FF");
  property p_src_bad;
    tx_req_in && !tx_busy_out && my_addr_in == 8'hFF |=> tx_refused_out && !tx_busy_out;
  endproperty
  a_src_bad: assert property (p_src_bad)
    else $error("request with source FF not refused");
  property p_len_bad;
    tx_req_in && !tx_busy_out && tx_len_in > 16'h05E5 |=> tx_refused_out && !tx_busy_out;
  endproperty
  a_len_bad: assert property (p_len_bad)
    else $error("oversize length not refused");
  property p_token;
    tx_req_in && !tx_busy_out && tx_type_in > 8'h02 && (!token_held_in || pass_due_out)
      |=> tx_refused_out && !tx_busy_out;
  endproperty
  a_token: assert property (p_token)
    else $error("data frame started without token");
  property p_pass;
    pass_due_out |-> token_held_in;
  endproperty
  a_pass: assert property (p_pass)
    else $error("pass due without token");
  property p_oe;
    tx_valid_out |-> !drv_oe_n_out;
  endproperty
  a_oe: assert property (p_oe)
    else $error("octet offered with driver off");
  property p_done;
    tx_done_out |=> !tx_done_out && !tx_busy_out;
  endproperty
  a_done: assert property (p_done)
    else $error("done pulse or busy too long");
  property p_tick;
    tick_5ms_out && seen_r |-> cnt_r == TICK_CYC - 1;
  endproperty
  a_tick: assert property (p_tick)
    else $error("tick period wrong");
  property p_tick_gap;
    seen_r |-> cnt_r < TICK_CYC;
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("tick missing");
  property p_hdr;
    rx_hdr_valid_out |-> $past(rx_hchk_ok_in) && rx_src_out != 8'hFF
      && (rx_dest_out == my_addr_in || rx_dest_out == 8'hFF);
  endproperty
  a_hdr: assert property (p_hdr)
    else $error("header accepted wrongly");
  property p_kind;
    rx_hdr_valid_out |-> rx_kind_out == ((rx_type_out == 8'h0A) ? 3'h3
      : (rx_type_out < 8'h03) ? rx_type_out[2:0] : 3'h4);
  endproperty
  a_kind: assert property (p_kind)
    else $error("frame kind wrong");
  property p_derr;
    rx_data_err_out |-> !$past(rx_dchk_ok_in);
  endproperty
  a_derr: assert property (p_derr)
    else $error("data error without bad check");
endmodule

`default_nettype wire

// ---- tbfc_bus_node.sv ----
`timescale 1ns/1ps
`default_nettype none

module tbfc_bus_node (
  input  wire logic       clk_in,
  input  wire logic       slow_in,
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_byte_in,
  output var  logic       tx_ready_out,
  output var  logic       rx_valid_out,
  output var  logic [7:0] rx_byte_out
);
  logic [7:0] seen[$];
  logic [1:0] ph_r;

  initial begin
    tx_ready_out = 1'b0;
    rx_valid_out = 1'b0;
    rx_byte_out  = 8'h00;
    ph_r         = 2'h0;
  end

  always @(posedge clk_in) begin
    if (tx_valid_in && tx_ready_out) seen.push_back(tx_byte_in);
    ph_r         <= ph_r + 2'h1;
    tx_ready_out <= !slow_in || (ph_r == 2'h3);
  end

  // one octet per pulse; idle line shows inverted data, not a stale copy
  task automatic send(input logic [7:0] b);
    @(posedge clk_in);
    rx_valid_out <= 1'b1;
    rx_byte_out  <= b;
    @(posedge clk_in);
    rx_valid_out <= 1'b0;
    rx_byte_out  <= ~b;
  endtask
endmodule

`default_nettype wire

// ---- tbfc_frame_codec_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module tbfc_frame_codec_test;
  localparam int         TICK = 10;
  localparam logic [7:0] MY   = 8'h05;
  logic        clk_in, rst_in, token_held_in, pass_due_out, tick_5ms_out, tx_req_in, tx_pad_in;
  logic        tx_busy_out, tx_refused_out, tx_done_out, pay_valid_in, pay_ready_out;
  logic        tx_valid_out, tx_ready_in, drv_oe_n_out, rx_valid_in, rx_hchk_ok_in, slow;
  logic        rx_dchk_ok_in, rx_hdr_valid_out, rx_data_valid_out, rx_frame_ok_out;
  logic        rx_hdr_err_out, rx_data_err_out;
  logic [7:0]  my_addr_in, max_frames_in, tx_type_in, tx_dest_in, tx_hchk_in, pay_data_in;
  logic [7:0]  tx_byte_out, rx_byte_in, rx_type_out, rx_dest_out, rx_src_out, rx_data_out, last_rd;
  logic [15:0] tx_len_in, rx_len_out;
  logic [2:0]  rx_kind_out;
  int          bad_count, num_checks, n_hv, n_ok, n_he, n_de, n_dv, n_dn;

  tbfc_frame_codec #(.TICK_CYC(TICK)) dut (.*);
  tbfc_bus_node node (.clk_in, .slow_in(slow), .tx_valid_in(tx_valid_out),
    .tx_byte_in(tx_byte_out), .tx_ready_out(tx_ready_in), .rx_valid_out(rx_valid_in),
    .rx_byte_out(rx_byte_in));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    n_hv += int'(rx_hdr_valid_out === 1'b1);
    n_ok += int'(rx_frame_ok_out === 1'b1);
    n_he += int'(rx_hdr_err_out === 1'b1);
    n_de += int'(rx_data_err_out === 1'b1);
    n_dv += int'(rx_data_valid_out === 1'b1);
    n_dn += int'(tx_done_out === 1'b1);
    if (rx_data_valid_out === 1'b1) last_rd = rx_data_out;
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic tx_frame(input logic [7:0] ty, input logic [15:0] ln, input logic pd, sw);
    logic [7:0] exp[$];
    int         n;
    int         k;
    int         d0;
    exp = '{8'h55, 8'hFF, ty, 8'h09, MY, ln[15:8], ln[7:0], 8'h3C};
    d0 = n_dn;
    n = (ln == 16'h0) ? 0 : int'(ln) + 2;
    k = 0;
    node.seen.delete();
    @(posedge clk_in);
    slow <= sw;
    for (int i = 0; i < n; i++) begin
      pay_valid_in <= 1'b1;
      pay_data_in  <= 8'h20 + 8'(i);
      exp.push_back(8'h20 + 8'(i));
      @(posedge clk_in);
    end
    pay_valid_in <= 1'b0;
    if (pd) exp.push_back(8'hFF);
    #1 if (n == 16) chk("fifo ready", 16'h0, 16'(pay_ready_out));
    @(posedge clk_in);
    tx_req_in  <= 1'b1;
    tx_type_in <= ty;
    tx_len_in  <= ln;
    tx_pad_in  <= pd;
    @(posedge clk_in);
    tx_req_in <= 1'b0;
    #1 chk("busy", 16'h1, 16'(tx_busy_out));
    while (!(tx_busy_out === 1'b0 && drv_oe_n_out === 1'b1) && k < 300) begin
      @(posedge clk_in);
      #1 k++;
    end
    chk("octet count", 16'(exp.size()), 16'(node.seen.size()));
    chk("done pulses", 16'h1, 16'(n_dn - d0));
    foreach (exp[i]) chk("octet", {8'h0, exp[i]}, {8'h0, node.seen[i]});
  endtask

  task automatic refuse(input logic [7:0] ty, input logic [15:0] ln);
    @(posedge clk_in);
    tx_req_in  <= 1'b1;
    tx_type_in <= ty;
    tx_len_in  <= ln;
    @(posedge clk_in);
    tx_req_in <= 1'b0;
    #1 chk("refused", 16'h1, 16'(tx_refused_out));
    chk("idle", 16'h0, 16'(tx_busy_out));
  endtask

  task automatic rx_frame(input logic [7:0] ty, ds, sr, input logic [15:0] ln,
                          input logic ho, dk, input logic [3:0] ev, input int dv);
    int         c[5];
    logic [7:0] hb[8];
    c = '{n_hv, n_ok, n_he, n_de, n_dv};
    hb = '{8'h55, 8'hFF, ty, ds, sr, ln[15:8], ln[7:0], 8'hA5};
    @(posedge clk_in);
    rx_hchk_ok_in <= ho;
    rx_dchk_ok_in <= dk;
    foreach (hb[i]) node.send(hb[i]);
    for (int i = 0; i < ((ln == 16'h0) ? 0 : int'(ln) + 2); i++) node.send(8'h30 + 8'(i));
    repeat (4) @(posedge clk_in);
    #1 chk("hdr valid", 16'(ev[3]), 16'(n_hv - c[0]));
    chk("frame ok", 16'(ev[2]), 16'(n_ok - c[1]));
    chk("hdr err", 16'(ev[1]), 16'(n_he - c[2]));
    chk("data err", 16'(ev[0]), 16'(n_de - c[3]));
    chk("data octets", 16'(dv), 16'(n_dv - c[4]));
    if (dv > 0) chk("last data", 16'(8'h30 + 8'(dv - 1)), 16'(last_rd));
    if (ev[3]) begin
      chk("type", {8'h0, ty}, {8'h0, rx_type_out});
      chk("kind", (ty == 8'h0A) ? 16'h3 : (ty < 8'h03) ? {8'h0, ty} : 16'h4,
          {13'h0, rx_kind_out});
      chk("addr", {ds, sr}, {rx_dest_out, rx_src_out});
      chk("len", ln, rx_len_out);
    end
  endtask

  task automatic t_tx;
    #1 chk("oe idle", 16'h1, 16'(drv_oe_n_out));
    tx_frame(8'h00, 16'h0, 1'b1, 1'b0);
    tx_frame(8'h01, 16'h0, 1'b0, 1'b0);
    tx_frame(8'h02, 16'h0, 1'b0, 1'b0);
    @(posedge clk_in);
    token_held_in <= 1'b1;
    tx_frame(8'h0A, 16'h000E, 1'b0, 1'b1);
    #1 chk("pass due", 16'h1, 16'(pass_due_out));
    refuse(8'h0A, 16'h0003);
    tx_frame(8'h00, 16'h0, 1'b0, 1'b0);
    @(posedge clk_in);
    token_held_in <= 1'b0;
    refuse(8'h0A, 16'h0003);
    refuse(8'h01, 16'h05E6);
    @(posedge clk_in);
    my_addr_in <= 8'hFF;
    refuse(8'h02, 16'h0);
    @(posedge clk_in);
    my_addr_in <= MY;
    $display("end transmit tests");
  endtask

  task automatic t_rx;
    logic [7:0] ts[5];
    ts = '{8'h00, 8'h01, 8'h02, 8'h0A, 8'h7F};
    foreach (ts[i]) rx_frame(ts[i], MY, 8'h03, 16'h0, 1'b1, 1'b1, 4'b1100, 0);
    rx_frame(8'h0A, 8'hFF, 8'h03, 16'h1, 1'b1, 1'b1, 4'b1100, 3);
    rx_frame(8'h0A, MY, 8'h03, 16'h1, 1'b1, 1'b0, 4'b1001, 3);
    rx_frame(8'h0A, MY, 8'h03, 16'h1, 1'b0, 1'b1, 4'b0010, 0);
    rx_frame(8'h00, MY, 8'hFF, 16'h0, 1'b1, 1'b1, 4'b0000, 0);
    rx_frame(8'h00, 8'h22, 8'h03, 16'h0, 1'b1, 1'b1, 4'b0000, 0);
    node.send(8'hFF);
    node.send(8'h55);
    rx_frame(8'h01, MY, 8'h04, 16'h0, 1'b1, 1'b1, 4'b1100, 0);
    $display("end receive tests");
  endtask

  task automatic t_tick;
    int k;
    repeat (2) begin
      k = 0;
      do begin
        @(posedge clk_in);
        #1 k++;
      end while (tick_5ms_out !== 1'b1 && k < 50);
    end
    chk("tick gap", 16'(TICK), 16'(k));
    $display("end tick test");
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    {rst_in, token_held_in, tx_req_in, tx_pad_in, pay_valid_in, slow} = 6'b100000;
    {rx_hchk_ok_in, rx_dchk_ok_in} = 2'b00;
    {my_addr_in, max_frames_in, tx_type_in, tx_dest_in} = {MY, 8'h01, 8'h00, 8'h09};
    {tx_hchk_in, pay_data_in, tx_len_in} = {8'h3C, 8'h00, 16'h0};
    {bad_count, num_checks, n_hv, n_ok, n_he, n_de, n_dv, n_dn} = '0;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    t_tx();
    t_rx();
    t_tick();
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    bad_count++;
    $display("[ERR] run end exp done got hang");
    summarize();
  end
endmodule

bind tbfc_frame_codec tbfc_frame_codec_sva #(.TICK_CYC(TICK_CYC)) u_sva (.*);

`default_nettype wire
